/* design/mwd_pkg.sv */
// Purpose: Constants and carrier types of the millisecond watchdog.
// Assumes: Avalon-MM byte addresses, register index times four.
// Notes: Status and mask share one bit layout.
package mwd_pkg;
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] CTRL_IDX = 12'h0D6;
    localparam logic [ADDR_W-1:0] DIS_IDX = 12'h0D7;
    localparam logic [ADDR_W-1:0] FREQ_IDX = 12'h051;
    localparam logic [ADDR_W-1:0] STAT_IDX = 12'h0D8;
    localparam logic [ADDR_W-1:0] MASK_IDX = 12'h0D9;
    localparam logic [ADDR_W-1:0] CTRL_ADDR = {CTRL_IDX[ADDR_W-3:0], 2'h0};
    localparam logic [ADDR_W-1:0] DIS_ADDR = {DIS_IDX[ADDR_W-3:0], 2'h0};
    localparam logic [ADDR_W-1:0] FREQ_ADDR = {FREQ_IDX[ADDR_W-3:0], 2'h0};
    localparam logic [ADDR_W-1:0] STAT_ADDR = {STAT_IDX[ADDR_W-3:0], 2'h0};
    localparam logic [ADDR_W-1:0] MASK_ADDR = {MASK_IDX[ADDR_W-3:0], 2'h0};
    localparam logic [15:0] TIMEOUT_RST = 16'h03E8;
    localparam logic [15:0] COUNT_RST = 16'h0000;
    localparam logic [31:0] DIS_KEY = 32'h0D15AB1E;
    localparam logic [6:0] FREQ_RST = 7'h19;
    localparam logic [6:0] FREQ_MIN = 7'h05;
    localparam logic [6:0] FREQ_MAX = 7'h64;
    localparam int TICK_US = 1000;
    localparam int PRESC_W = 17;
    localparam int ST_EXPIRE = 0;
    localparam int ST_NACK = 1;
    localparam int ST_W = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    typedef struct packed {
        logic read;
        logic write;
        logic [ADDR_W-1:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } mwd_av_req_t;
    typedef struct packed {
        logic waitrequest;
        logic [31:0] readdata;
        logic [1:0] response;
    } mwd_av_rsp_t;
    typedef struct packed {
        logic [15:0] timeout;
        logic [15:0] count;
        logic [31:0] dis_val;
        logic enabled;
        logic [6:0] freq;
        logic [PRESC_W-1:0] presc;
        logic [ST_W-1:0] status;
        logic [ST_W-1:0] mask;
        mwd_av_rsp_t rsp;
        logic irq;
        logic tile_rst;
    } mwd_state_t;
    localparam mwd_state_t STATE_RST = '{
        timeout: TIMEOUT_RST, count: COUNT_RST, dis_val: DIS_KEY, enabled: 1'b0,
        freq: FREQ_RST, presc: '0, status: '0, mask: '0,
        rsp: '{waitrequest: 1'b1, readdata: 32'h0000_0000, response: RESP_OKAY},
        irq: 1'b0, tile_rst: 1'b0};
endpackage : mwd_pkg

/* design/mwd_watchdog.sv */
// Purpose: Millisecond watchdog with guarded kick and key disable.
// Assumes: Avalon-MM slave with waitrequest, one clock, sync reset.
// Notes: Every access answers one cycle after it is seen.
//
// Summary of operation
// R1: Countdown decrements once per millisecond tick; timeout is in milliseconds.
// R2: Timeout spans one millisecond to about sixty-five seconds, sixteen bits.
// R3: Ticks reach the counter only in the full power state.
// R4: Software writes timeout low and its one's complement high together.
// R5: Control writes with bad complement or partial byteenable are refused with error, others acknowledged.
// R6: Accepted control write restarts countdown from the new timeout.
// R7: Expiry while enabled resets the processor tile.
// R8: Control read returns present count in bits 31:16, read-only, reset zero.
// R9: Control bits 15:0 hold the timeout, read-write, reset 1000.
// R10: Writing the disable key clears the counter and stops the watchdog.
// R11: Writing zero to the disable register enables the watchdog.
// R12: Software should kick more often than the programmed timeout.
// R13: Tick comes from system clock using frequency in MHz, 5 to 100.
// R14: Watchdog leaves reset disabled until zero is written.
// R15: Outside full power the counter holds its value.
`timescale 1ns/1ps
module mwd_watchdog (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic full_power_state_i,
    input wire mwd_pkg::mwd_av_req_t avs_i,
    output mwd_pkg::mwd_av_rsp_t avs_o,
    output logic irq_o,
    output logic tile_reset_o
);
    import mwd_pkg::*;

    mwd_state_t s_r;
    mwd_state_t s_nxt;
    logic tick;
    logic expire;
    logic commit;
    logic ctrl_ok;
    logic freq_ok;
    logic [ST_W-1:0] ev;
    logic [ST_W-1:0] clr;

    // Cycles of the system clock in one millisecond
    function automatic logic [PRESC_W-1:0] ms_cycles(input logic [6:0] mhz);
        ms_cycles = PRESC_W'(mhz * TICK_US);
    endfunction : ms_cycles

    function automatic logic cpl_ok(input logic [31:0] d);
        cpl_ok = (d[31:16] == ~d[15:0]);
    endfunction : cpl_ok

    assign avs_o = s_r.rsp;
    assign irq_o = s_r.irq;
    assign tile_reset_o = s_r.tile_rst;

    always_comb begin
        s_nxt = s_r;
        s_nxt.tile_rst = 1'b0;
        tick = 1'b0;
        expire = 1'b0;
        ev = '0;
        clr = '0;
        ctrl_ok = cpl_ok(avs_i.writedata) && (avs_i.byteenable == 4'hF); // [R4] [R5]
        freq_ok = (avs_i.writedata[6:0] >= FREQ_MIN) && (avs_i.writedata[6:0] <= FREQ_MAX)
            && (avs_i.writedata[31:7] == 25'h0000000);
        commit = avs_i.write && !s_r.rsp.waitrequest && (s_r.rsp.response == RESP_OKAY);

        // Millisecond prescaler, free-running; its tick is gated by power state
        if (s_r.presc >= ms_cycles(s_r.freq) - PRESC_W'(1)) begin // [R13]
            s_nxt.presc = '0;
            tick = full_power_state_i; // [R3]
        end else begin
            s_nxt.presc = s_r.presc + PRESC_W'(1);
        end

        // Countdown; while enabled, without a tick the count holds; while disabled it is cleared
        if (!s_r.enabled) begin
            s_nxt.count = COUNT_RST; // [R10]
        end else if (tick) begin // [R15]
            if (s_r.count <= 16'h0001) begin
                expire = 1'b1; // [R7]
                s_nxt.count = s_r.timeout;
            end else begin
                s_nxt.count = s_r.count - 16'h0001; // [R1] [R2]
            end
        end
        s_nxt.tile_rst = expire;
        ev[ST_EXPIRE] = expire;

        // Bus slave: decode on first cycle, commit when waitrequest is low
        if ((avs_i.read || avs_i.write) && s_r.rsp.waitrequest) begin
            s_nxt.rsp.waitrequest = 1'b0;
            s_nxt.rsp.readdata = 32'h0000_0000;
            s_nxt.rsp.response = RESP_OKAY;
            case (avs_i.address)
                CTRL_ADDR: begin
                    s_nxt.rsp.readdata = {s_r.count, s_r.timeout}; // [R8] [R9]
                    if (avs_i.write && !ctrl_ok) begin
                        s_nxt.rsp.response = RESP_SLVERR; // [R5]
                    end
                end
                DIS_ADDR: s_nxt.rsp.readdata = s_r.dis_val;
                FREQ_ADDR: begin
                    s_nxt.rsp.readdata = {25'h0000000, s_r.freq};
                    if (avs_i.write && !freq_ok) begin
                        s_nxt.rsp.response = RESP_SLVERR; // [R13]
                    end
                end
                STAT_ADDR: s_nxt.rsp.readdata = {30'h00000000, s_r.status};
                MASK_ADDR: s_nxt.rsp.readdata = {30'h00000000, s_r.mask};
                default: s_nxt.rsp.response = RESP_DECERR;
            endcase
            if (avs_i.write && (avs_i.byteenable != 4'hF) && (s_nxt.rsp.response == RESP_OKAY)) begin
                s_nxt.rsp.response = RESP_SLVERR;
            end
            if (avs_i.write && (s_nxt.rsp.response == RESP_SLVERR)) begin
                ev[ST_NACK] = 1'b1;
            end
        end else begin
            s_nxt.rsp.waitrequest = 1'b1;
        end

        if (commit) begin
            case (avs_i.address)
                CTRL_ADDR: begin
                    s_nxt.timeout = avs_i.writedata[15:0]; // [R9]
                    s_nxt.count = avs_i.writedata[15:0]; // [R6]
                end
                DIS_ADDR: begin
                    s_nxt.dis_val = avs_i.writedata;
                    if (avs_i.writedata == DIS_KEY) begin
                        s_nxt.enabled = 1'b0; // [R10]
                        s_nxt.count = COUNT_RST;
                    end else if (avs_i.writedata == 32'h0000_0000) begin
                        s_nxt.enabled = 1'b1; // [R11]
                        s_nxt.count = s_r.timeout;
                    end
                end
                FREQ_ADDR: begin
                    s_nxt.freq = avs_i.writedata[6:0]; // [R13]
                    // Restart the prescaler so a shorter period never starts overrun
                    s_nxt.presc = '0;
                end
                STAT_ADDR: clr = avs_i.writedata[ST_W-1:0];
                MASK_ADDR: s_nxt.mask = avs_i.writedata[ST_W-1:0];
                default: ;
            endcase
        end

        // Sticky events; a new event beats a same-cycle clear
        s_nxt.status = (s_r.status & ~clr) | ev;
        s_nxt.irq = |(s_nxt.status & s_nxt.mask);
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            s_r <= STATE_RST; // [R14]
        end else begin
            s_r <= s_nxt;
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    chk_nack_bad_cpl: assert property ( // [R5]
        (!avs_o.waitrequest && avs_i.write && avs_i.address == CTRL_ADDR
            && !cpl_ok(avs_i.writedata)) |-> avs_o.response == RESP_SLVERR)
        else $error("bad complement not refused");

    chk_kick_reload: assert property ( // [R6]
        (commit && avs_i.address == CTRL_ADDR) |=> s_r.count == $past(avs_i.writedata[15:0]))
        else $error("kick did not reload count");

    chk_tick_step: assert property ( // [R1]
        (tick && s_r.enabled && s_r.count > 16'h0001 && !commit)
            |=> s_r.count == $past(s_r.count) - 16'h0001)
        else $error("count not decremented on tick");

    chk_full_power_state_only: assert property (!full_power_state_i |-> !tick) // [R3]
        else $error("tick outside full power");

    chk_hold_asleep: assert property ( // [R15]
        (!full_power_state_i && s_r.enabled && !commit) |=> $stable(s_r.count))
        else $error("count moved while asleep");

    chk_expiry_reset: assert property ( // [R7]
        (tick && s_r.enabled && s_r.count <= 16'h0001) |=> tile_reset_o ##1 !tile_reset_o)
        else $error("expiry without tile reset");

    chk_key_disable: assert property ( // [R10]
        (commit && avs_i.address == DIS_ADDR && avs_i.writedata == DIS_KEY)
            |=> !s_r.enabled && s_r.count == COUNT_RST ##1 !tile_reset_o)
        else $error("key did not disable");

    chk_zero_enable: assert property ( // [R11]
        (commit && avs_i.address == DIS_ADDR && avs_i.writedata == 32'h0000_0000) |=> s_r.enabled)
        else $error("zero did not enable");

    chk_count_read: assert property ( // [R8]
        (!avs_o.waitrequest && avs_i.read && avs_i.address == CTRL_ADDR)
            |-> avs_o.readdata[31:16] == $past(s_r.count))
        else $error("read count mismatch");

    chk_presc_range: assert property (s_r.presc < ms_cycles(s_r.freq)) // [R13]
        else $error("prescaler past period");

    chk_tick_period: assert property (tick |-> s_r.presc == ms_cycles(s_r.freq) - PRESC_W'(1)) // [R1] [R13]
        else $error("tick off the millisecond boundary");

    chk_freq_valid: assert property (s_r.freq >= FREQ_MIN && s_r.freq <= FREQ_MAX) // [R13]
        else $error("freq setting out of range");

    chk_freq_refuse: assert property ( // [R13]
        (!avs_o.waitrequest && avs_i.write && avs_i.address == FREQ_ADDR
            && (avs_i.writedata[6:0] < FREQ_MIN || avs_i.writedata[6:0] > FREQ_MAX))
            |-> avs_o.response == RESP_SLVERR)
        else $error("freq out of range accepted");

    chk_freq_load: assert property ( // [R13]
        (commit && avs_i.address == FREQ_ADDR) |=> s_r.freq == $past(avs_i.writedata[6:0]) && s_r.presc == '0)
        else $error("freq write not applied");

    // Bus answers
    chk_wait_one: assert property (!avs_o.waitrequest |=> avs_o.waitrequest)
        else $error("answer longer than one cycle");

    chk_decode_err: assert property (
        (!avs_o.waitrequest && avs_i.address != CTRL_ADDR && avs_i.address != DIS_ADDR
            && avs_i.address != FREQ_ADDR && avs_i.address != STAT_ADDR && avs_i.address != MASK_ADDR)
            |-> avs_o.response == RESP_DECERR)
        else $error("unmapped address not refused");

    chk_good_cpl_ack: assert property ( // [R5]
        (!avs_o.waitrequest && avs_i.write && avs_i.address == CTRL_ADDR && avs_i.byteenable == 4'hF
            && cpl_ok(avs_i.writedata)) |-> avs_o.response == RESP_OKAY)
        else $error("good complement not acknowledged");

    chk_refused_keep: assert property ( // [R5]
        (!avs_o.waitrequest && avs_i.write && avs_o.response != RESP_OKAY)
            |=> $stable(s_r.timeout) && $stable(s_r.dis_val) && $stable(s_r.freq) && $stable(s_r.mask))
        else $error("refused write took effect");

    chk_nack_status: assert property ( // [R5]
        (!avs_o.waitrequest && avs_i.write && avs_o.response == RESP_SLVERR) |-> s_r.status[ST_NACK])
        else $error("refused write left no status");

    // Register contents
    chk_timeout_load: assert property ( // [R9]
        (commit && avs_i.address == CTRL_ADDR) |=> s_r.timeout == $past(avs_i.writedata[15:0]))
        else $error("timeout not stored");

    chk_timeout_read: assert property ( // [R9]
        (!avs_o.waitrequest && avs_i.read && avs_i.address == CTRL_ADDR)
            |-> avs_o.readdata[15:0] == $past(s_r.timeout))
        else $error("read timeout mismatch");

    chk_count_bound: assert property (s_r.count <= s_r.timeout) // [R2]
        else $error("count above timeout");

    chk_disabled_zero: assert property ( // [R10]
        (!s_r.enabled && !commit) |=> s_r.count == COUNT_RST)
        else $error("count moved while disabled");

    chk_disabled_quiet: assert property (!s_r.enabled |=> !tile_reset_o) // [R10]
        else $error("tile reset while disabled");

    chk_dis_store: assert property ( // [R10]
        (commit && avs_i.address == DIS_ADDR) |=> s_r.dis_val == $past(avs_i.writedata))
        else $error("disable register not stored");

    chk_dis_read: assert property ( // [R10]
        (!avs_o.waitrequest && avs_i.read && avs_i.address == DIS_ADDR)
            |-> avs_o.readdata == $past(s_r.dis_val))
        else $error("disable register read mismatch");

    chk_enable_load: assert property ( // [R11]
        (commit && avs_i.address == DIS_ADDR && avs_i.writedata == 32'h0000_0000)
            |=> s_r.count == $past(s_r.timeout))
        else $error("enable did not load timeout");

    chk_other_keep: assert property ( // [R11]
        (commit && avs_i.address == DIS_ADDR && avs_i.writedata != 32'h0000_0000 && avs_i.writedata != DIS_KEY)
            |=> s_r.enabled == $past(s_r.enabled))
        else $error("other value changed enable");

    chk_stays_off: assert property ( // [R14]
        (!s_r.enabled && !(commit && avs_i.address == DIS_ADDR && avs_i.writedata == 32'h0000_0000))
            |=> !s_r.enabled)
        else $error("enabled without zero write");

    chk_reset_state: assert property (disable iff (1'b0) // [R14]
        rst_i |=> !s_r.enabled && s_r.count == COUNT_RST && s_r.timeout == TIMEOUT_RST && s_r.dis_val == DIS_KEY
            && avs_o.waitrequest && !irq_o && !tile_reset_o)
        else $error("state after reset wrong");

    chk_tile_cause: assert property ( // [R7] [R3]
        tile_reset_o |-> $past(s_r.enabled) && $past(full_power_state_i))
        else $error("tile reset without enabled expiry");

    chk_tile_pulse: assert property (tile_reset_o |=> !tile_reset_o) // [R7]
        else $error("tile reset longer than one cycle");

    chk_expire_status: assert property (tile_reset_o |-> s_r.status[ST_EXPIRE]) // [R7]
        else $error("expiry left no status");

    chk_irq_level: assert property (irq_o == |(s_r.status & s_r.mask))
        else $error("irq not following masked status");

    cov_expiry: cover property (s_r.enabled ##1 tile_reset_o);
    cov_nack: cover property (!avs_o.waitrequest && avs_o.response == RESP_SLVERR);
    cov_kick: cover property (commit && avs_i.address == CTRL_ADDR);
    cov_irq: cover property ($rose(irq_o));
endmodule : mwd_watchdog

/* verification/tb_top.sv */
// Purpose: Self-checking bench of the millisecond watchdog.
// Assumes: Frequency register set to 5, one tick per 5000 clocks.
// Notes: Bus tasks hold each request until waitrequest is seen low.
`timescale 1ns/1ps
module tb_top;
    import mwd_pkg::*;
    logic clock_i;
    logic rst_i;
    logic full_power_state_i;
    mwd_av_req_t req;
    mwd_av_rsp_t rsp;
    logic irq_o;
    logic tile_reset_o;
    int n_fail = 0;
    int checks = 0;
    int n_rst = 0;
    logic [3:0] be_sel = 4'hF;
    mwd_watchdog i_dut (.clock_i(clock_i), .rst_i(rst_i), .full_power_state_i(full_power_state_i),
        .avs_i(req), .avs_o(rsp), .irq_o(irq_o), .tile_reset_o(tile_reset_o));
    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end
    // Counts tile reset pulses
    always @(posedge clock_i) begin
        if (tile_reset_o === 1'b1) begin
            n_rst <= n_rst + 1;
        end
    end
    task automatic end_sim();
        if (n_fail == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic [1:0] r);
        int n;
        n = 0;
        req.read <= ~w;
        req.write <= w;
        req.address <= a;
        req.writedata <= d;
        req.byteenable <= be_sel;
        @(posedge clock_i);
        while (rsp.waitrequest !== 1'b0 && n < 50) begin
            @(posedge clock_i);
            n++;
        end
        q = rsp.readdata;
        r = rsp.response;
        req.read <= 1'b0;
        req.write <= 1'b0;
        // Idle edge so the next request never reassigns in this time step
        @(posedge clock_i);
        if (n >= 50) chk(32'h1, 32'h0);
    endtask : acc
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [31:0] q;
        logic [1:0] r;
        acc(1'b1, a, d, q, r);
        chk({30'h0, r}, {30'h0, er});
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e, input logic [1:0] er);
        logic [31:0] q;
        logic [1:0] r;
        acc(1'b0, a, 32'h0, q, r);
        chk(q, e);
        chk({30'h0, r}, {30'h0, er});
    endtask : rd
    task automatic wait_rst(input int lim, output int c);
        int n0;
        n0 = n_rst;
        c = 0;
        while (n_rst == n0 && c < lim) begin
            @(posedge clock_i);
            c++;
        end
    endtask : wait_rst
    task automatic t_reset();
        rd(CTRL_ADDR, 32'h000003E8, RESP_OKAY);
        rd(DIS_ADDR, DIS_KEY, RESP_OKAY);
        rd(12'hFFC, 32'h0, RESP_DECERR);
    endtask : t_reset
    task automatic t_nack();
        wr(FREQ_ADDR, 32'h00000005, RESP_OKAY);
        wr(MASK_ADDR, 32'h00000003, RESP_OKAY);
        wr(CTRL_ADDR, 32'h00000002, RESP_SLVERR);
        wr(FREQ_ADDR, 32'h00000004, RESP_SLVERR);
        wr(FREQ_ADDR, 32'h00000065, RESP_SLVERR);
        be_sel = 4'h3;
        wr(CTRL_ADDR, 32'hFFFD0002, RESP_SLVERR);
        be_sel = 4'hF;
        rd(CTRL_ADDR, 32'h000003E8, RESP_OKAY);
        rd(FREQ_ADDR, 32'h00000005, RESP_OKAY);
        chk({31'h0, irq_o}, 32'h1);
        wr(STAT_ADDR, 32'h00000002, RESP_OKAY);
        repeat (2) @(posedge clock_i);
        chk({31'h0, irq_o}, 32'h0);
        rd(STAT_ADDR, 32'h00000000, RESP_OKAY);
    endtask : t_nack
    task automatic t_expire();
        int c;
        // No ticks while the count is set up and read back
        full_power_state_i <= 1'b0;
        wr(CTRL_ADDR, 32'hFFFD0002, RESP_OKAY);
        rd(CTRL_ADDR, 32'h00000002, RESP_OKAY);
        wr(DIS_ADDR, 32'h0, RESP_OKAY);
        rd(CTRL_ADDR, 32'h00020002, RESP_OKAY);
        full_power_state_i <= 1'b1;
        wait_rst(12000, c);
        chk({31'h0, c > 5000 && c < 10010}, 32'h1);
        rd(STAT_ADDR, 32'h00000001, RESP_OKAY);
        chk({31'h0, irq_o}, 32'h1);
        wr(STAT_ADDR, 32'h00000001, RESP_OKAY);
    endtask : t_expire
    task automatic t_power();
        int c;
        int n0;
        full_power_state_i <= 1'b0;
        wr(CTRL_ADDR, 32'hFFFE0001, RESP_OKAY);
        n0 = n_rst;
        repeat (6000) @(posedge clock_i);
        chk(n_rst, n0);
        rd(CTRL_ADDR, 32'h00010001, RESP_OKAY);
        full_power_state_i <= 1'b1;
        wait_rst(5100, c);
        chk({31'h0, c < 5100}, 32'h1);
    endtask : t_power
    // Kicks 4000 cycles apart against a 2 ms timeout: never expires
    task automatic t_kick();
        int n0;
        wr(CTRL_ADDR, 32'hFFFD0002, RESP_OKAY);
        n0 = n_rst;
        repeat (3) begin
            repeat (4000) @(posedge clock_i);
            wr(CTRL_ADDR, 32'hFFFD0002, RESP_OKAY);
        end
        chk(n_rst, n0);
    endtask : t_kick
    task automatic t_key();
        int n0;
        wr(CTRL_ADDR, 32'h0000FFFF, RESP_OKAY);
        wr(DIS_ADDR, DIS_KEY, RESP_OKAY);
        rd(CTRL_ADDR, 32'h0000FFFF, RESP_OKAY);
        n0 = n_rst;
        repeat (6000) @(posedge clock_i);
        chk(n_rst, n0);
        rd(DIS_ADDR, DIS_KEY, RESP_OKAY);
    endtask : t_key
    initial begin
        rst_i = 1'b1;
        full_power_state_i = 1'b1;
        req = '0;
        repeat (4) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        t_reset();
        t_nack();
        t_expire();
        t_power();
        t_kick();
        t_key();
        end_sim();
    end
    initial begin
        #400000;
        n_fail++;
        end_sim();
    end
endmodule : tb_top
